// File: logic/mde_consts.svh
// register offsets, field positions, reset values and opcode codes
`ifndef MDE_CONSTS_SVH
`define MDE_CONSTS_SVH
`define MDE_OFF_OPCODE 8'h00
`define MDE_OFF_ACC 8'h04
`define MDE_OFF_STATUS 8'h08
`define MDE_OFF_CONTROL 8'h0c
`define MDE_ST_C 0
`define MDE_ST_HALF_CARRY 1
`define MDE_ST_Z 2
`define MDE_ST_POWERDOWN 3
`define MDE_ST_WDT_EXPIRY 4
`define MDE_ST_BUSY 5
`define MDE_CTL_PRESC_TMR 0
`define MDE_CTL_RESET 8'h00
`define MDE_ACC_RESET 8'h00
`define MDE_TIMER_ADDR 7'h01
`define MDE_PORT_ADDR 7'h06
`define MDE_LOW_STANDBY 8'h63
`define MDE_LOW_WDT_CLEAR 8'h64
`define MDE_HI_SYSTEM 6'h00
`define MDE_HI_IOR 6'h38
`define MDE_HI_XOR 6'h3a
`define MDE_HI_RETURN_LIT 4'hd
`define MDE_HI_LIT_SUB 5'h1e
`define MDE_HI_LIT_ADD 5'h1f
`define MDE_HI_AND_FILE 6'h05
`define MDE_HI_ADD_FILE 6'h07
`define MDE_HI_BIT_CLEAR 4'h4
`endif

// File: logic/mde_pkg.sv
// types shared by the opcode decode and execute block
`default_nettype none
package mde_pkg;
    typedef enum logic [3:0] {
        MDE_OP_NONE,
        MDE_OP_STANDBY,
        MDE_OP_WDT_CLEAR,
        MDE_OP_IOR,
        MDE_OP_XOR,
        MDE_OP_RETURN_LIT,
        MDE_OP_LIT_SUB,
        MDE_OP_LIT_ADD,
        MDE_OP_AND_FILE,
        MDE_OP_ADD_FILE,
        MDE_OP_BIT_CLEAR
    } mde_op_e;
    typedef struct packed {
        logic wdt_expiry;
        logic powerdown;
        logic z;
        logic half_carry;
        logic c;
    } mde_status_s;
    typedef struct packed {
        logic standby_enter;
        logic watchdog_restart;
        logic return_pop;
        logic prescaler_clear;
    } mde_events_s;
endpackage
`default_nettype wire

// File: logic/mde_core.sv
// opcode decode and execute core with an apb register port
//
// The placing of the registers and the APB register port were chosen for this implementation.
`include "mde_consts.svh"
`default_nettype none
module mde_core #(
    parameter int FILE_DEPTH = 128,
    parameter int PORT_WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // port pins
    input wire logic [PORT_WIDTH-1:0] port_pins,
    output logic [PORT_WIDTH-1:0] port_latch,
    // core events
    output mde_pkg::mde_events_s events
);
    import mde_pkg::*;

    typedef enum {
        MDE_IDLE,
        MDE_EXEC,
        MDE_SECOND
    } mde_state_e;

    // file index is a bit slice, so the depth must be a power of two
    if (FILE_DEPTH < 8 || FILE_DEPTH > 128 ||
            (FILE_DEPTH & (FILE_DEPTH - 1)) != 0 ||
            PORT_WIDTH != 8) begin : g_bad
        $error("mde_core: unsupported FILE_DEPTH or PORT_WIDTH");
    end

    mde_state_e state_reg;
    logic [13:0] opcode_reg;
    logic [7:0] acc_reg;
    logic [7:0] ctrl_reg;
    mde_status_s status_reg;
    mde_events_s events_reg;
    logic [7:0] file_reg [FILE_DEPTH];
    logic [7:0] port_latch_reg;
    logic [7:0] pins_meta_reg;
    logic [7:0] pins_sync_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    // decoding is shared by the execute path and the busy logic
    function automatic mde_op_e decode(input logic [13:0] op);
        decode = MDE_OP_NONE;
        if (op[13:8] == `MDE_HI_SYSTEM && op[7:0] == `MDE_LOW_STANDBY)
            decode = MDE_OP_STANDBY;
        else if (op[13:8] == `MDE_HI_SYSTEM && op[7:0] == `MDE_LOW_WDT_CLEAR)
            decode = MDE_OP_WDT_CLEAR;
        else if (op[13:8] == `MDE_HI_IOR)
            decode = MDE_OP_IOR;
        else if (op[13:8] == `MDE_HI_XOR)
            decode = MDE_OP_XOR;
        else if (op[13:10] == `MDE_HI_RETURN_LIT)
            decode = MDE_OP_RETURN_LIT;
        else if (op[13:9] == `MDE_HI_LIT_SUB)
            decode = MDE_OP_LIT_SUB;
        else if (op[13:9] == `MDE_HI_LIT_ADD)
            decode = MDE_OP_LIT_ADD;
        else if (op[13:8] == `MDE_HI_AND_FILE)
            decode = MDE_OP_AND_FILE;
        else if (op[13:8] == `MDE_HI_ADD_FILE)
            decode = MDE_OP_ADD_FILE;
        else if (op[13:10] == `MDE_HI_BIT_CLEAR)
            decode = MDE_OP_BIT_CLEAR;
    endfunction

    // apb access decode
    logic setup_ok;
    logic access;
    logic wr_access;
    logic mapped;
    logic issue;
    assign access = psel & penable & ~pready_reg;
    // writes land only at the edge where the master sees pready high
    assign wr_access = psel & penable & pready_reg & pwrite;
    assign mapped = paddr == `MDE_OFF_OPCODE || paddr == `MDE_OFF_ACC ||
                    paddr == `MDE_OFF_STATUS || paddr == `MDE_OFF_CONTROL;
    assign setup_ok = state_reg == MDE_IDLE;
    // opcodes written while busy are dropped; software polls busy
    assign issue = wr_access & setup_ok & (paddr == `MDE_OFF_OPCODE);

    // execute datapath
    mde_op_e op;
    logic [6:0] faddr;
    logic dest;
    logic [2:0] bidx;
    logic [7:0] lit;
    logic [7:0] fval;
    logic [7:0] result;
    logic [8:0] sum;
    logic half;
    logic to_acc;
    logic to_file;
    logic set_cz;
    logic set_z;

    assign op = decode(opcode_reg);
    assign faddr = opcode_reg[6:0];
    assign dest = opcode_reg[7];
    assign bidx = opcode_reg[9:7];
    assign lit = opcode_reg[7:0];
    // port reads see the pins so an externally held-low input writes back low
    assign fval = (faddr == `MDE_PORT_ADDR) ? pins_sync_reg :
                  file_reg[faddr[$clog2(FILE_DEPTH)-1:0]];

    always_comb begin
        result = acc_reg;
        sum = 9'h000;
        half = 1'b0;
        to_acc = 1'b0;
        to_file = 1'b0;
        set_cz = 1'b0;
        set_z = 1'b0;
        case (op)
            MDE_OP_IOR: begin
                result = acc_reg | lit;
                to_acc = 1'b1;
                set_z = 1'b1;
            end
            MDE_OP_XOR: begin
                result = acc_reg ^ lit;
                to_acc = 1'b1;
                set_z = 1'b1;
            end
            MDE_OP_RETURN_LIT: begin
                result = lit;
                to_acc = 1'b1;
            end
            MDE_OP_LIT_SUB: begin
                // carry means no borrow: literal not below accumulator
                sum = {1'b0, lit} + {1'b0, ~acc_reg} + 9'h001;
                half = lit[3:0] >= acc_reg[3:0];
                result = sum[7:0];
                to_acc = 1'b1;
                set_cz = 1'b1;
            end
            MDE_OP_LIT_ADD: begin
                sum = {1'b0, acc_reg} + {1'b0, lit};
                half = ({1'b0, acc_reg[3:0]} + {1'b0, lit[3:0]}) > 5'h0f;
                result = sum[7:0];
                to_acc = 1'b1;
                set_cz = 1'b1;
            end
            MDE_OP_AND_FILE: begin
                result = acc_reg & fval;
                to_acc = ~dest;
                to_file = dest;
                set_z = 1'b1;
            end
            MDE_OP_ADD_FILE: begin
                sum = {1'b0, acc_reg} + {1'b0, fval};
                half = ({1'b0, acc_reg[3:0]} + {1'b0, fval[3:0]}) > 5'h0f;
                result = sum[7:0];
                to_acc = ~dest;
                to_file = dest;
                set_cz = 1'b1;
            end
            MDE_OP_BIT_CLEAR: begin
                result = fval & ~(8'h01 << bidx);
                to_file = 1'b1;
            end
            default: begin
                result = acc_reg;
            end
        endcase
    end

    logic executing;
    assign executing = state_reg == MDE_EXEC;

    // sequencing: one cycle, or two when the program counter moves
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= MDE_IDLE;
        end else begin
            case (state_reg)
                MDE_IDLE: begin
                    if (issue)
                        state_reg <= MDE_EXEC;
                end
                MDE_EXEC: begin
                    if (op == MDE_OP_RETURN_LIT)
                        state_reg <= MDE_SECOND;
                    else
                        state_reg <= MDE_IDLE;
                end
                MDE_SECOND: begin
                    state_reg <= MDE_IDLE;
                end
                default: begin
                    state_reg <= MDE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            opcode_reg <= 14'h0000;
        else if (issue)
            opcode_reg <= pwdata[13:0];
    end

    // accumulator: execution has priority, apb write only when idle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            acc_reg <= `MDE_ACC_RESET;
        else if (executing && to_acc)
            acc_reg <= result;
        else if (wr_access && setup_ok && paddr == `MDE_OFF_ACC)
            acc_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_reg <= `MDE_CTL_RESET;
        else if (wr_access && paddr == `MDE_OFF_CONTROL)
            ctrl_reg <= pwdata[7:0];
    end

    // status flags; power-on leaves both watchdog flags set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_reg <= '{wdt_expiry: 1'b1, powerdown: 1'b1, z: 1'b0,
                half_carry: 1'b0, c: 1'b0};
        end else if (executing) begin
            if (set_cz) begin
                status_reg.c <= sum[8];
                status_reg.half_carry <= half;
            end
            if (set_cz || set_z)
                status_reg.z <= result == 8'h00;
            if (op == MDE_OP_STANDBY) begin
                status_reg.wdt_expiry <= 1'b1;
                status_reg.powerdown <= 1'b0;
            end else if (op == MDE_OP_WDT_CLEAR) begin
                status_reg.wdt_expiry <= 1'b1;
                status_reg.powerdown <= 1'b1;
            end
        end
    end

    // file storage in flip-flops, written by index
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < FILE_DEPTH; i++)
                file_reg[i] <= 8'h00;
        end else if (executing && to_file) begin
            file_reg[faddr[$clog2(FILE_DEPTH)-1:0]] <= result;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            port_latch_reg <= 8'h00;
        else if (executing && to_file && faddr == `MDE_PORT_ADDR)
            port_latch_reg <= result;
    end

    // pins are asynchronous to pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_meta_reg <= 8'h00;
            pins_sync_reg <= 8'h00;
        end else begin
            pins_meta_reg <= port_pins;
            pins_sync_reg <= pins_meta_reg;
        end
    end

    // one-cycle event pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events_reg <= '0;
        end else begin
            events_reg.standby_enter <= executing &&
                op == MDE_OP_STANDBY;
            events_reg.watchdog_restart <= executing &&
                op == MDE_OP_WDT_CLEAR;
            events_reg.return_pop <= executing &&
                op == MDE_OP_RETURN_LIT;
            events_reg.prescaler_clear <= executing && to_file &&
                faddr == `MDE_TIMER_ADDR &&
                ctrl_reg[`MDE_CTL_PRESC_TMR];
        end
    end

    // apb answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access;
            pslverr_reg <= access & ~mapped;
            prdata_reg <= 32'h0000_0000;
            if (access && !pwrite) begin
                case (paddr)
                    `MDE_OFF_OPCODE: prdata_reg <= {18'h00000, opcode_reg};
                    `MDE_OFF_ACC: prdata_reg <= {24'h000000, acc_reg};
                    `MDE_OFF_STATUS: prdata_reg <= {26'h0000000,
                        !setup_ok, status_reg};
                    `MDE_OFF_CONTROL: prdata_reg <= {24'h000000, ctrl_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign port_latch = port_latch_reg;
    assign events = events_reg;
endmodule
`default_nettype wire

// File: testbench/mde_core_monitor.sv
// assertion checker bound to the decode and execute core
`default_nettype none
module mde_core_monitor
    import mde_pkg::*;
#(
    parameter int PORT_WIDTH = 8
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and events
    input wire logic [PORT_WIDTH-1:0] port_pins,
    input wire logic [PORT_WIDTH-1:0] port_latch,
    input wire mde_pkg::mde_events_s events
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic taken;
    logic opw;
    assign taken = psel && penable && !pready;
    // an opcode write commits at the edge that shows pready high
    assign opw = psel && penable && pready && pwrite && paddr == 8'h00;
    AST_PREADY_LATE: assert property (taken |=> pready)
        else $error("pready missing after access cycle");
    AST_PREADY_PULSE: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> $past(taken))
        else $error("pready without an access");
    AST_UNMAPPED: assert property (taken && (paddr > 8'h0c
        || paddr[1:0] != 2'b00) |=> pready && pslverr)
        else $error("unmapped access not flagged");
    AST_MAPPED: assert property (taken && paddr <= 8'h0c
        && paddr[1:0] == 2'b00 |=> !pslverr)
        else $error("mapped access flagged as error");
    AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data not zero outside answer");
    AST_STANDBY: assert property (events.standby_enter |->
        $past(opw && pwdata[13:0] == 14'h0063, 2))
        else $error("standby pulse without its opcode");
    AST_WDT: assert property (events.watchdog_restart |->
        $past(opw && pwdata[13:0] == 14'h0064, 2))
        else $error("watchdog pulse without its opcode");
    AST_RETURN: assert property (events.return_pop |->
        $past(opw && pwdata[13:10] == 4'hd, 2))
        else $error("return pulse without its opcode");
    AST_EVT_PULSE: assert property (events != 4'h0 |=> events == 4'h0)
        else $error("event pulse longer than one cycle");
    COV_STANDBY: cover property (events.standby_enter);
    COV_RETURN: cover property (events.return_pop);
    COV_PRESC: cover property (events.prescaler_clear);
    COV_ERR: cover property (pslverr);
endmodule
bind mde_core mde_core_monitor #(.PORT_WIDTH(PORT_WIDTH)) u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_pins(port_pins),
    .port_latch(port_latch), .events(events));
`default_nettype wire

// File: testbench/mcu_opcode_decode_execute_tb_top.sv
// self-checking testbench for the decode and execute core
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module mcu_opcode_decode_execute_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import mde_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, port_pins, port_latch;
    logic [31:0] pwdata, prdata, rd;
    mde_events_s events;
    int fail_count, num_checks, pclr_cnt, ret_cnt, sby_cnt, wdr_cnt;
    mde_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .port_pins(port_pins), .port_latch(port_latch), .events(events));
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (events.prescaler_clear === 1'b1) pclr_cnt++;
        if (events.return_pop === 1'b1) ret_cnt++;
        if (events.standby_enter === 1'b1) sby_cnt++;
        if (events.watchdog_restart === 1'b1) wdr_cnt++;
    end
    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // one apb transfer left open so that another may follow at once
    task automatic apb_go(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
    endtask
    // one apb transfer; an idle edge after it keeps drivers race free
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        apb_go(w, a, d);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e,
            input string nm);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask
    task automatic lit(input logic [7:0] acc, input logic [13:0] op,
            input logic [7:0] ea, input logic [5:0] es);
        apb(1'b1, 8'h04, {24'h0, acc});
        apb(1'b1, 8'h00, {18'h0, op});
        chk_rd(8'h04, {24'h0, ea}, "acc");
        chk_rd(8'h08, {26'h0, es}, "status");
    endtask
    task automatic t_reset;
        chk_rd(8'h08, 32'h18, "status reset");
        chk_rd(8'h0c, 32'h0, "control reset");
        apb(1'b0, 8'h10, 32'h0);
        `CHK("slverr", 1'b1, err)
    endtask
    task automatic t_literal;
        lit(8'hf8, 14'h3e0f, 8'h07, 6'h1b);
        lit(8'h05, 14'h3c05, 8'h00, 6'h1f);
        lit(8'h06, 14'h3c05, 8'hff, 6'h18);
        lit(8'h00, 14'h3800, 8'h00, 6'h1c);
        lit(8'h50, 14'h3881, 8'hd1, 6'h18);
        lit(8'h5a, 14'h3a5a, 8'h00, 6'h1c);
        lit(8'h11, 14'h3477, 8'h77, 6'h1c);
        lit(8'h77, 14'h0063, 8'h77, 6'h14);
        lit(8'h77, 14'h0064, 8'h77, 6'h1c);
        `CHK("return pulse", 1, ret_cnt)
        `CHK("standby pulse", 1, sby_cnt)
        `CHK("watchdog pulse", 1, wdr_cnt)
    endtask
    // a status read right behind the opcode write sees the extra cycle
    task automatic t_busy;
        apb_go(1'b1, 8'h00, 32'h3455);
        apb_go(1'b0, 8'h08, 32'h0);
        `CHK("busy return", 32'h3c, rd)
        apb_go(1'b1, 8'h00, 32'h3800);
        apb_go(1'b0, 8'h08, 32'h0);
        `CHK("busy or", 32'h18, rd)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        `CHK("return pulse", 2, ret_cnt)
    endtask
    task automatic t_file;
        lit(8'h3c, 14'h07a0, 8'h3c, 6'h18);
        lit(8'h3c, 14'h1120, 8'h3c, 6'h18);
        lit(8'h0f, 14'h0520, 8'h08, 6'h18);
        lit(8'h07, 14'h0520, 8'h00, 6'h1c);
        lit(8'hc8, 14'h05a0, 8'hc8, 6'h18);
        lit(8'hf8, 14'h0720, 8'h00, 6'h1f);
    endtask
    // timer storage sits at file 01h
    task automatic t_timer;
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b1, 8'h00, 32'h0781);
        repeat (2) @(posedge pclk);
        `CHK("presc d1", 2, pclr_cnt)
        apb(1'b1, 8'h00, 32'h1001);
        repeat (2) @(posedge pclk);
        `CHK("presc bit clear", 3, pclr_cnt)
        apb(1'b1, 8'h00, 32'h0701);
        repeat (2) @(posedge pclk);
        `CHK("presc d0", 3, pclr_cnt)
        apb(1'b1, 8'h0c, 32'h0);
        apb(1'b1, 8'h00, 32'h0781);
        repeat (2) @(posedge pclk);
        `CHK("presc unassigned", 3, pclr_cnt)
    endtask
    // pins differ from the latch so a latch based modify shows up
    task automatic t_port;
        port_pins <= 8'ha5;
        repeat (3) @(posedge pclk);
        apb(1'b1, 8'h00, 32'h1006);
        @(posedge pclk);
        `CHK("latch", 8'ha4, port_latch)
        port_pins <= 8'h00;
        repeat (3) @(posedge pclk);
        apb(1'b1, 8'h00, 32'h1386);
        @(posedge pclk);
        `CHK("latch", 8'h00, port_latch)
    endtask
    initial begin
        #100000;
        fail_count++;
        wrap_up;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        port_pins = 8'h00;
        fail_count = 0;
        num_checks = 0;
        pclr_cnt = 1;
        ret_cnt = 0;
        sby_cnt = 0;
        wdr_cnt = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_literal;
        t_busy;
        t_file;
        t_timer;
        t_port;
        wrap_up;
    end
endmodule
`default_nettype wire
